/* File: hss_pkg.sv */
// Package with constants shared by both ends of the switch serial control port.
package hss_pkg;
	localparam int WORD_W = 16; // Bits in one serial word.
	localparam int CNT_W = 5; // Width of bit counters.
	localparam int ADDR_W = 5; // Width of the address field.
	localparam int ADDR_MSB = 14; // Top bit of the address field.
	localparam int ADDR_LSB = 10; // Bottom bit of the address field.
	localparam int DATA_W = 10; // Width of the register data field.
	localparam int NREG = 32; // Number of addressable registers.
	localparam int NIN = 4; // Number of direct inputs and outputs.
	localparam int CLK_MHZ = 100; // System clock rate.
	localparam int SCLK_MAX_KHZ = 8000; // Fastest allowed serial clock.
	localparam int SCLK_HALF = (CLK_MHZ * 1000 + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ);
	localparam int T_RST_US = 10; // Least reset low time.
	localparam int RST_CYC = T_RST_US * CLK_MHZ; // Cycles of reset low.
	localparam int T_CS_NS = 1000; // Chip select high between frames.
	localparam int CS_CYC = (T_CS_NS * CLK_MHZ + 999) / 1000; // Cycles between frames.
	localparam int T_ENBL_NS = 5000; // Reset release to first frame.
	localparam int ENBL_CYC = (T_ENBL_NS * CLK_MHZ + 999) / 1000; // Cycles after reset.
	localparam logic [15:0] REG_RESET = 16'h0000; // Reset value of every register.
	localparam logic [1:0] SNS_OFF = 2'h0; // Sense output high impedance.
	localparam logic [1:0] SNS_CUR = 2'h1; // Sense routes output current.
	localparam logic [1:0] SNS_TMP = 2'h2; // Sense routes board temperature.
	localparam logic [4:0] ADDR_OUT = 5'h01; // Register holding output and PWM control.
	localparam logic [4:0] ADDR_SNS = 5'h02; // Register holding sense routing.
endpackage

/* File: hss_if.sv */
// Interface joining the host and the switch over the serial control port.
`timescale 1ns/1ps
interface hss_if;
	logic sclk; // Serial clock from the host.
	logic cs_n; // Chip select, active low.
	logic si; // Serial data host to device.
	logic so_o; // Device serial output value.
	logic so_oe_n; // Device serial output enable, low drives.
	logic so; // Resolved serial output wire.
	logic rst_n; // Device reset pin, active low.
	logic wake; // Wake pin.
	logic fault_o; // Fault flag drive value.
	logic fault_oe_n; // Fault flag enable, low pulls down.
	logic fault_flag_n; // Resolved fault flag with pull-up.
	assign so = so_oe_n ? 1'b1 : so_o;
	assign fault_flag_n = fault_oe_n ? 1'b1 : fault_o;
	modport host (output sclk, cs_n, si, rst_n, wake, input so, fault_flag_n);
	modport dev (input sclk, cs_n, si, rst_n, wake, output so_o, so_oe_n, fault_o, fault_oe_n);
endinterface

/* File: hss_fifo.sv */
// Small FIFO of flip-flops with valid and ready on both sides.
`timescale 1ns/1ps
module hss_fifo #(
	parameter int W = 16, // Word width.
	parameter int D = 8 // Depth in words.
) (
	input  wire logic         clk,     // System clock.
	input  wire logic         rstn,    // Synchronous reset, active low.
	input  wire logic [W-1:0] in_data, // Word to store.
	input  wire logic         in_valid, // Word offered.
	output logic              in_ready, // Room for a word.
	output logic      [W-1:0] out_data, // Oldest word.
	output logic              out_valid, // A word is held.
	input  wire logic         out_ready // Consumer takes the word.
);
	localparam int AW = $clog2(D);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} hss_fifo_s;
	hss_fifo_s s_q, s_d;
	logic push, pop;
	// Pointers wrap at the depth; the count gives honest full and empty.
	always_comb begin
		s_d = s_q;
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		if (push) begin
			s_d.mem[s_q.wp] = in_data;
			s_d.wp = (s_q.wp == AW'(D - 1)) ? '0 : s_q.wp + 1'b1;
		end
		if (pop) begin
			s_d.rp = (s_q.rp == AW'(D - 1)) ? '0 : s_q.rp + 1'b1;
		end
		s_d.cnt = s_q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
	end
	// Registers the state.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign in_ready = (s_q.cnt != (AW + 1)'(D));
	assign out_valid = (s_q.cnt != '0);
	assign out_data = s_q.mem[s_q.rp];
endmodule

/* File: hss_dev.sv */
// Switch end: serial slave, register file, wake logic, outputs and fault flag.
// Functional notes
// - Transfer only while chip select low.
// - Chip select rise writes addressed register.
// - Chip select fall loads status word.
// - Host moves chip select only with clock low.
// - Sample input on serial clock fall.
// - Shift output on serial clock rise.
// - Sixteen bit words, most significant first.
// - Five bit address selects register.
// - Serial clock no faster than 8 MHz.
// - Host holds reset low 10 us.
// - Chip select high 1 us between frames.
// - Wait 5 us after reset release.
// - Reset clears registers, enters sleep.
// - Reset release starts watchdog timer.
// - Reset, wake or direct input wakes.
// - Direct inputs drive outputs; input zero clocks PWM.
// - Fault pulls flag low; details serially.
// - Sense routes current or temperature, or floats.
// - Lost logic supply gives fail-safe.
// - Sleep clears all serial configuration.
`timescale 1ns/1ps
module hss_dev (
	input  wire logic                    clk,           // System clock, 100 MHz.
	input  wire logic                    rstn,          // Synchronous reset, active low.
	hss_if.dev                           bus,           // Serial link pins.
	input  wire logic [hss_pkg::NIN-1:0] direct_inputs, // Direct input pins.
	input  wire logic [hss_pkg::NIN-1:0] fault_in,      // Per-output fault causes.
	input  wire logic                    vdd_ok,        // Logic supply present.
	output logic [hss_pkg::NIN-1:0]      high_side_outputs, // Switch commands.
	output logic [1:0]                   sense_output,  // Sense routing select.
	output logic [1:0]                   sense_chan,    // Output whose current is sensed.
	output logic                         asleep,        // Device in sleep.
	output logic                         fail_safe,     // Device in fail-safe.
	output logic                         wdog_run,      // Watchdog running.
	output logic                         pwm_clk        // External PWM clock.
);
	localparam int W = hss_pkg::WORD_W;
	localparam int N = hss_pkg::NIN;
	// Pin samples and shift state, all kept in one struct.
	typedef struct packed {
		logic [1:0] sclk_s, cs_s, si_s, rst_s, wake_s;
		logic [1:0][N-1:0] in_s;
		logic [1:0] vdd_s;
		logic sclk_p, cs_p, rst_p;
		logic [W-1:0] rx;
		logic [W-1:0] tx;
		logic [4:0] nbits;
		logic so_o, so_oe_n, fault_oe_n;
		logic [hss_pkg::NREG-1:0][hss_pkg::DATA_W-1:0] regs;
		logic [N-1:0] hs;
		logic [1:0] sns;
		logic [1:0] sch;
		logic sleep, fsafe, wdog, pclk;
	} hss_dev_s;
	hss_dev_s s_q, s_d;
	logic sclk_r, sclk_f, cs_f, cs_r, wake_up, any_fault;
	logic [hss_pkg::ADDR_W-1:0] addr;
	logic [hss_pkg::DATA_W-1:0] ctl;
	// Next state: two-flop pin samplers, then edge detection on the second stage only.
	always_comb begin
		s_d = s_q;
		s_d.sclk_s = {s_q.sclk_s[0], bus.sclk};
		s_d.cs_s = {s_q.cs_s[0], bus.cs_n};
		s_d.si_s = {s_q.si_s[0], bus.si};
		s_d.rst_s = {s_q.rst_s[0], bus.rst_n};
		s_d.wake_s = {s_q.wake_s[0], bus.wake};
		s_d.in_s = {s_q.in_s[0], direct_inputs};
		s_d.vdd_s = {s_q.vdd_s[0], vdd_ok};
		s_d.sclk_p = s_q.sclk_s[1];
		s_d.cs_p = s_q.cs_s[1];
		s_d.rst_p = s_q.rst_s[1];
		sclk_r = s_q.sclk_s[1] && !s_q.sclk_p;
		sclk_f = !s_q.sclk_s[1] && s_q.sclk_p;
		cs_f = !s_q.cs_s[1] && s_q.cs_p;
		cs_r = s_q.cs_s[1] && !s_q.cs_p;
		addr = s_q.rx[hss_pkg::ADDR_MSB:hss_pkg::ADDR_LSB];
		ctl = s_q.regs[hss_pkg::ADDR_OUT];
		any_fault = |fault_in;
		wake_up = s_q.rst_s[1] || s_q.wake_s[1] || (|s_q.in_s[1]);
		// Status word: fault bits, output states, mode flags.
		if (cs_f) begin
			s_d.tx = {s_q.sleep, s_q.fsafe, any_fault, 5'h00, fault_in, s_q.hs};
			s_d.nbits = '0;
			s_d.so_oe_n = 1'b0;
			s_d.so_o = s_q.sleep;
		end else if (!s_q.cs_s[1]) begin
			if (sclk_r && s_q.nbits != 5'h00) begin
				s_d.tx = {s_q.tx[W-2:0], 1'b0};
				s_d.so_o = s_q.tx[W-2];
			end
			if (sclk_f) begin
				s_d.rx = {s_q.rx[W-2:0], s_q.si_s[1]};
				if (s_q.nbits != 5'h1f) begin
					s_d.nbits = s_q.nbits + 5'h01;
				end
			end
		end else begin
			s_d.so_oe_n = 1'b1;
		end
		// Commit only a full word; a short frame is dropped.
		if (cs_r && s_q.nbits == 5'(W)) begin
			s_d.regs[addr] = s_q.rx[hss_pkg::DATA_W-1:0];
		end
		s_d.sleep = !wake_up;
		s_d.fsafe = !s_q.vdd_s[1] && wake_up;
		if (!wake_up) begin
			s_d.regs = '0;
		end
		if (s_q.rst_s[1] && !s_q.rst_p) begin
			s_d.wdog = 1'b1;
		end
		if (!s_q.rst_s[1]) begin
			s_d.regs = '0;
			s_d.wdog = 1'b0;
		end
		// Bit 9 enables PWM, bits 3..0 are serial on bits.
		s_d.pclk = ctl[9] && s_q.in_s[1][0];
		if (!wake_up) begin
			s_d.hs = '0;
		end else if (s_q.fsafe || !ctl[9]) begin
			s_d.hs = (s_q.in_s[1] | ctl[N-1:0]) & ~fault_in;
		end else begin
			s_d.hs = ctl[N-1:0] & ~fault_in;
		end
		s_d.sns = s_q.regs[hss_pkg::ADDR_SNS][1:0];
		s_d.sch = s_q.regs[hss_pkg::ADDR_SNS][3:2];
		s_d.fault_oe_n = !(any_fault && wake_up);
	end
	// Registers the state.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_q <= '0;
			s_q.so_oe_n <= 1'b1;
			s_q.fault_oe_n <= 1'b1;
			s_q.sleep <= 1'b1;
			s_q.cs_s <= 2'h3;
			s_q.cs_p <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end
	assign bus.so_o = s_q.so_o;
	assign bus.so_oe_n = s_q.so_oe_n;
	assign bus.fault_o = 1'b0;
	assign bus.fault_oe_n = s_q.fault_oe_n;
	assign high_side_outputs = s_q.hs;
	assign sense_output = s_q.sns;
	assign sense_chan = s_q.sch;
	assign asleep = s_q.sleep;
	assign fail_safe = s_q.fsafe;
	assign wdog_run = s_q.wdog;
	assign pwm_clk = s_q.pclk;
endmodule

/* File: hss_host.sv */
// Host end: queues words in a FIFO and runs serial frames to the switch.
`timescale 1ns/1ps
module hss_host #(
	parameter int DEPTH = 8 // FIFO depth in words.
) (
	input  wire logic                        clk,       // System clock, 100 MHz.
	input  wire logic                        rstn,      // Synchronous reset, active low.
	hss_if.host                              bus,       // Serial link pins.
	input  wire logic [hss_pkg::WORD_W-1:0] tx_data,   // Word to send.
	input  wire logic                        tx_valid,  // Word offered.
	output logic                             tx_ready,  // FIFO has room.
	input  wire logic                        dev_reset, // Request a device reset pulse.
	input  wire logic                        wake_req,  // Level for the wake pin.
	output logic [hss_pkg::WORD_W-1:0]       rx_data,   // Status word read back.
	output logic                             rx_valid,  // Pulse: status word ready.
	output logic                             fault_seen // Sampled fault flag, high on fault.
);
	localparam int W = hss_pkg::WORD_W;
	typedef enum {ST_RST, ST_ENBL, ST_IDLE, ST_LEAD, ST_LO, ST_HI, ST_LAG, ST_GAP} hss_st_e;
	typedef struct packed {
		hss_st_e st;
		logic [15:0] cnt;
		logic [4:0] nb;
		logic [W-1:0] sh;
		logic [W-1:0] rx;
		logic sclk, cs_n, si, rst_n, wake, rxv;
		logic [1:0] so_s, fs_s;
	} hss_host_s;
	hss_host_s s_q, s_d;
	logic [W-1:0] f_data;
	logic f_valid, f_ready;
	hss_fifo #(.W(W), .D(DEPTH)) u_fifo (
		.clk(clk), .rstn(rstn), .in_data(tx_data), .in_valid(tx_valid),
		.in_ready(tx_ready), .out_data(f_data), .out_valid(f_valid), .out_ready(f_ready)
	);
	// Frame sequencer; the clock half period keeps the serial rate within bound.
	always_comb begin
		s_d = s_q;
		f_ready = 1'b0;
		s_d.rxv = 1'b0;
		s_d.so_s = {s_q.so_s[0], bus.so};
		s_d.fs_s = {s_q.fs_s[0], bus.fault_flag_n};
		s_d.wake = wake_req;
		if (s_q.cnt != '0) begin
			s_d.cnt = s_q.cnt - 16'h0001;
		end
		case (s_q.st)
			ST_RST: begin
				s_d.rst_n = 1'b0;
				if (s_q.cnt == '0) begin
					s_d.rst_n = 1'b1;
					s_d.cnt = 16'(hss_pkg::ENBL_CYC);
					s_d.st = ST_ENBL;
				end
			end
			ST_ENBL: if (s_q.cnt == '0) s_d.st = ST_IDLE;
			ST_IDLE: begin
				if (dev_reset) begin
					s_d.cnt = 16'(hss_pkg::RST_CYC);
					s_d.st = ST_RST;
				end else if (f_valid) begin
					f_ready = 1'b1;
					s_d.sh = f_data;
					s_d.si = f_data[W-1];
					s_d.cs_n = 1'b0;
					s_d.nb = '0;
					s_d.cnt = 16'(hss_pkg::SCLK_HALF);
					s_d.st = ST_LEAD;
				end
			end
			ST_LEAD, ST_LO: if (s_q.cnt == '0) begin
				// The switch samples on the clock fall, so the next bit moves on the rise.
				// Moving it on the fall would race the switch's own sampling of that fall.
				if (s_q.st == ST_LO) begin
					s_d.si = s_q.sh[W-1];
				end
				s_d.sclk = 1'b1;
				s_d.cnt = 16'(hss_pkg::SCLK_HALF);
				s_d.st = ST_HI;
			end
			ST_HI: if (s_q.cnt == '0) begin
				s_d.sclk = 1'b0;
				s_d.rx = {s_q.rx[W-2:0], s_q.so_s[1]};
				s_d.sh = {s_q.sh[W-2:0], 1'b0};
				s_d.nb = s_q.nb + 5'h01;
				s_d.cnt = 16'(hss_pkg::SCLK_HALF);
				s_d.st = (s_q.nb == 5'(W - 1)) ? ST_LAG : ST_LO;
			end
			ST_LAG: if (s_q.cnt == '0) begin
				s_d.cs_n = 1'b1;
				s_d.rxv = 1'b1;
				s_d.cnt = 16'(hss_pkg::CS_CYC);
				s_d.st = ST_GAP;
			end
			ST_GAP: if (s_q.cnt == '0) s_d.st = ST_IDLE;
			default: s_d.st = ST_IDLE;
		endcase
	end
	// Registers the state; reset also pulses the device reset pin.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_q <= '0;
			s_q.st <= ST_RST;
			s_q.cnt <= 16'(hss_pkg::RST_CYC);
			s_q.cs_n <= 1'b1;
			s_q.fs_s <= 2'h3;
		end else begin
			s_q <= s_d;
		end
	end
	assign bus.sclk = s_q.sclk;
	assign bus.cs_n = s_q.cs_n;
	assign bus.si = s_q.si;
	assign bus.rst_n = s_q.rst_n;
	assign bus.wake = s_q.wake;
	assign rx_data = s_q.rx;
	assign rx_valid = s_q.rxv;
	assign fault_seen = !s_q.fs_s[1];
endmodule

/* File: hss_props.sv */
// Checker of the serial link between the host end and the switch end.
`timescale 1ns/1ps
module hss_props (
	input  wire logic clk,     // System clock.
	input  wire logic rstn,    // Bench reset, active low.
	input  wire logic sclk,    // Serial clock from the host.
	input  wire logic cs_n,    // Chip select, active low.
	input  wire logic si,      // Serial data to the switch.
	input  wire logic so_o,    // Switch serial output value.
	input  wire logic so_oe_n, // Switch serial output enable, low drives.
	input  wire logic rst_n    // Switch reset pin, active low.
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	logic [10:0] low_q; // Cycles of reset pin low.
	logic [10:0] up_q;  // Cycles since reset pin release.
	logic [7:0]  gap_q; // Cycles of chip select high.
	logic [4:0]  nb_q;  // Clock falls seen in this frame.
	// The reset and gap counters saturate so a long idle spell cannot wrap into a short count.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			low_q <= '0;
			up_q <= '0;
			gap_q <= '0;
			nb_q <= '0;
		end else begin
			low_q <= rst_n ? 11'h000 : low_q + 11'(low_q != 11'h7ff);
			up_q <= !rst_n ? 11'h000 : up_q + 11'(up_q != 11'h7ff);
			gap_q <= !cs_n ? 8'h00 : gap_q + 8'(gap_q != 8'hff);
			nb_q <= cs_n ? 5'h00 : nb_q + 5'($fell(sclk));
		end
	end
	// One cycle of slack in the gaps below covers sampling of the counters.
	idle_tristate_a: assert property (cs_n [*4] |-> so_oe_n)
		else $error("serial output driven while deselected");
	drive_in_frame_a: assert property ($fell(so_oe_n) |-> !cs_n)
		else $error("serial output enabled outside a frame");
	so_hold_a: assert property ($fell(sclk) && !so_oe_n |=> $stable(so_o) [*4])
		else $error("serial output moved after a clock fall");
	cs_clk_low_a: assert property ($changed(cs_n) |-> !sclk && !$past(sclk))
		else $error("chip select moved with clock high");
	idle_clk_low_a: assert property (cs_n && $past(cs_n) |-> !sclk)
		else $error("serial clock high while deselected");
	clk_high_min_a: assert property ($rose(sclk) |-> sclk [*7])
		else $error("serial clock high phase too short");
	clk_low_min_a: assert property ($fell(sclk) && !cs_n |-> !sclk [*7])
		else $error("serial clock low phase too short");
	frame_bits_a: assert property ($rose(cs_n) |-> nb_q == 5'h10)
		else $error("frame did not carry sixteen bits");
	si_steady_a: assert property (sclk && $past(sclk) |-> $stable(si))
		else $error("serial input moved while clock high");
	reset_width_a: assert property ($rose(rst_n) |-> low_q >= hss_pkg::RST_CYC - 1)
		else $error("reset pin low time too short");
	enable_wait_a: assert property ($fell(cs_n) |-> up_q >= hss_pkg::ENBL_CYC - 1)
		else $error("frame started too soon after reset");
	frame_gap_a: assert property ($fell(cs_n) |-> gap_q >= hss_pkg::CS_CYC - 1)
		else $error("chip select gap too short");
endmodule

/* File: hss_tb_top.sv */
// Testbench joining host and switch ends with a reference model of the status word.
`timescale 1ns/1ps
module hss_tb_top;
	logic        clk = 1'b0;          // System clock.
	logic        rstn = 1'b0;         // Bench reset, active low.
	logic [15:0] tx_data = '0;        // Word offered to the host.
	logic        tx_valid = 1'b0;     // Offer strobe.
	logic        dev_reset = 1'b0;    // Switch reset request.
	logic        wake_req = 1'b1;     // Wake pin level.
	logic [3:0]  direct_inputs = '0;  // Direct input pins.
	logic [3:0]  fault_in = '0;       // Fault causes.
	logic        vdd_ok = 1'b1;       // Logic supply present.
	logic        tx_ready, rx_valid, fault_seen, asleep, fail_safe, wdog_run, pwm_clk;
	logic [15:0] rx_data, w, e, mask; // Status, popped word, expectation, mask.
	logic [3:0]  hs, m_on = '0;       // Outputs and modelled on bits.
	logic [1:0]  sns, chan, c;        // Sense routing and a random channel.
	logic        m_pwm = 1'b0;        // Modelled PWM enable.
	logic [15:0] sent_q[$];           // Words sent, awaiting their status.
	int          n_errors = 0, n_tests = 0, cyc = 0, refused = 0;
	initial forever #5 clk = ~clk;
	hss_if hss_if_i ();
	hss_host #(.DEPTH(8)) hss_host_i (.clk(clk), .rstn(rstn), .bus(hss_if_i),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .dev_reset(dev_reset),
		.wake_req(wake_req), .rx_data(rx_data), .rx_valid(rx_valid), .fault_seen(fault_seen));
	hss_dev hss_dev_i (.clk(clk), .rstn(rstn), .bus(hss_if_i), .direct_inputs(direct_inputs),
		.fault_in(fault_in), .vdd_ok(vdd_ok), .high_side_outputs(hs), .sense_output(sns),
		.sense_chan(chan), .asleep(asleep), .fail_safe(fail_safe), .wdog_run(wdog_run),
		.pwm_clk(pwm_clk));
	hss_props hss_props_i (.clk(clk), .rstn(rstn), .sclk(hss_if_i.sclk), .cs_n(hss_if_i.cs_n),
		.si(hss_if_i.si), .so_o(hss_if_i.so_o), .so_oe_n(hss_if_i.so_oe_n),
		.rst_n(hss_if_i.rst_n));
	// Shared comparison; the caller names what is compared.
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// Offers one word and holds it until the FIFO takes it, counting refusals.
	task automatic push(input logic [15:0] word);
		@(negedge clk);
		tx_data = word;
		tx_valid = 1'b1;
		while (tx_ready !== 1'b1) begin
			refused++;
			@(negedge clk);
		end
		sent_q.push_back(word);
	endtask
	// Waits, bounded, until every sent word has been answered.
	task automatic drain();
		@(negedge clk);
		tx_valid = 1'b0;
		for (int i = 0; i < 30000 && sent_q.size() != 0; i++) @(negedge clk);
		repeat (120) @(negedge clk);
		check({15'h0, hss_if_i.so}, 16'h0001, "released output");
	endtask
	// Random word at any address, PWM bit kept clear so outputs stay predictable.
	function automatic logic [15:0] rnd_word();
		logic [15:0] r;
		r = 16'($urandom);
		r[15] = 1'b0;
		r[9] = 1'b0;
		return r;
	endfunction
	// Status is captured at frame start, so it reflects the state before this word's write.
	always @(negedge clk) begin
		if (rx_valid === 1'b1) begin
			w = sent_q.pop_front();
			// A faulted output is forced off, so its on bit reads back clear.
			e = {2'b00, |fault_in, 5'h00, fault_in, m_on & ~fault_in};
			mask = m_pwm ? 16'hfff0 : 16'hffff;
			check(rx_data & mask, e & mask, "status word");
			if (w[14:10] == hss_pkg::ADDR_OUT) begin
				m_on = w[3:0];
				m_pwm = w[9];
			end
		end
	end
	// A hang is cut short well beyond the expected run length.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 80000) begin
			n_errors++;
			$display("unexpected at %0t: run did not finish", $time);
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		void'($urandom(32'ha29a_e852));
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		// Pushing while the host still holds the switch in reset forces the FIFO full.
		for (int i = 0; i < 12; i++) push(rnd_word());
		drain();
		check(16'(refused != 0), 16'h0001, "fifo refusal");
		check({12'h0, hs}, {12'h0, m_on}, "outputs");
		for (int m = 0; m < 3; m++) begin
			c = 2'($urandom);
			push({1'b0, hss_pkg::ADDR_SNS, 6'h00, c, 2'(m)});
			drain();
			check({12'h0, chan, sns}, {12'h0, c, 2'(m)}, "sense routing");
		end
		fault_in = 4'($urandom_range(1, 15));
		repeat (20) @(negedge clk);
		check({14'h0, hss_if_i.fault_flag_n, fault_seen}, 16'h0001, "fault flag");
		push(rnd_word());
		drain();
		fault_in = '0;
		push({1'b0, hss_pkg::ADDR_OUT, 1'b1, 9'h00f});
		drain();
		for (int k = 0; k < 4; k++) begin
			direct_inputs = {3'b000, 1'(k)};
			repeat (10) @(negedge clk);
			check({15'h0, pwm_clk}, {15'h0, 1'(k)}, "pwm clock");
		end
		direct_inputs = '0;
		push({1'b0, hss_pkg::ADDR_OUT, 10'h000});
		drain();
		vdd_ok = 1'b0;
		repeat (20) @(negedge clk);
		check({15'h0, fail_safe}, 16'h0001, "fail safe");
		vdd_ok = 1'b1;
		wake_req = 1'b0;
		dev_reset = 1'b1;
		@(negedge clk);
		dev_reset = 1'b0;
		repeat (500) @(negedge clk);
		check({11'h0, asleep, hs}, 16'h0010, "reset sleep");
		repeat (1200) @(negedge clk);
		check({14'h0, wdog_run, asleep}, 16'h0002, "after reset");
		wake_req = 1'b1;
		m_on = '0;
		m_pwm = 1'b0;
		push(rnd_word());
		drain();
		give_verdict();
	end
endmodule
